// ===== logic/phs_pkg.sv
// Register map, field layout, reset values, timing counts and types of the push/hold standstill controller.
package phs_pkg;

  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TARGET = 8'h04;
  localparam logic [7:0] ADDR_BAND = 8'h08;
  localparam logic [7:0] ADDR_LIMITS = 8'h0c;
  localparam logic [7:0] ADDR_ZONE = 8'h10;
  localparam logic [7:0] ADDR_JUDGE = 8'h14;
  localparam logic [7:0] ADDR_DLY1 = 8'h18;
  localparam logic [7:0] ADDR_DLY2 = 8'h1c;
  localparam logic [7:0] ADDR_DLY3 = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_ALM_CLR = 8'h28;

  // Field positions.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_TCHK_BIT = 3;
  localparam int LIM_PUSH_LSB = 0;
  localparam int LIM_THR_LSB = 8;
  localparam int ZONE_LO_LSB = 0;
  localparam int ZONE_HI_LSB = 16;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_SERVO_BIT = 3;
  localparam int STAT_DONE_BIT = 4;
  localparam int STAT_LOAD_BIT = 5;
  localparam int STAT_ALARM_BIT = 6;
  localparam int STAT_CODE_LSB = 8;

  // Reset values.
  localparam logic [15:0] RST_JUDGE = 16'h0019;
  localparam logic [23:0] RST_DLY = 24'h0003e8;
  localparam logic [15:0] RST_BAND = 16'h000a;

  // Standstill field encodings.
  localparam logic [2:0] SS_NONE = 3'h0;
  localparam logic [2:0] SS_OFF1 = 3'h1;
  localparam logic [2:0] SS_OFF2 = 3'h2;
  localparam logic [2:0] SS_OFF3 = 3'h3;
  localparam logic [2:0] SS_FULL = 3'h4;

  // Alarm codes.
  localparam logic [1:0] ALM_NONE = 2'h0;
  localparam logic [1:0] ALM_EARLY = 2'h1;
  localparam logic [1:0] ALM_PUSHBACK = 2'h2;

  // Servo wake-up settling time before motion starts.
  localparam int CLK_PERIOD_NS = 40;
  localparam int WAKE_NS = 200;
  localparam logic [23:0] WAKE_CYC = 24'((WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAKE = 3'b001,
    ST_MOVE = 3'b010,
    ST_PUSH = 3'b011,
    ST_HOLD = 3'b100,
    ST_MISS = 3'b101,
    ST_DONE = 3'b110,
    ST_ALARM = 3'b111
  } phs_state_t;

  typedef struct packed {
    logic [2:0] ss_mode;
    logic tchk_off;
    logic signed [15:0] target;
    logic signed [15:0] band;
    logic [7:0] push_lim;
    logic [7:0] thresh;
    logic signed [15:0] zone_lo;
    logic signed [15:0] zone_hi;
    logic [15:0] judge;
    logic [23:0] dly1;
    logic [23:0] dly2;
    logic [23:0] dly3;
  } phs_cfg_t;

endpackage : phs_pkg

// ===== logic/phs_ctrl.sv
// Push/hold positioning sequencer with standstill power saving and an AHB-Lite register slave.
// How it works
// - Full servo mode: servo stays on, reduced current.
// - Auto-off mode: servo off after delay.
// - Servo off: next command wakes servo, then moves.
// - Push zero: plain positioning, no push phase.
// - Push nonzero: after target, push for band.
// - Push contact completion asserts position complete.
// - Completion: current limit held for judgement time.
// - Contact before target raises servo error alarm.
// - Band travelled without contact: complete stays low.
// - Yielding load: follow it within band.
// - Following: complete tracks current versus limit.
// - Pushed back: yield, keep complete asserted.
// - Pushed back to target raises alarm.
// - Check band on: torque in zone sets load.
// - Check band off: load follows torque level.
// - Standstill field: none, auto-off 1-3, full servo.
// - Plain positioning completes within band before target.
module phs_ctrl
  import phs_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK_IN,
  input wire logic RSTN_IN,
  // AHB-Lite slave.
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // Command pin from the PLC.
  input wire logic START_IN,
  // Feedback from the motion engine.
  input wire logic signed [15:0] ACT_POS_IN,
  input wire logic [7:0] MOTOR_CUR_IN,
  input wire logic [7:0] CMD_TORQUE_IN,
  // Outputs to the PLC and the motion engine.
  output logic POS_DONE_OUT,
  output logic LOAD_OUT,
  output logic ALARM_OUT,
  output logic SERVO_ON_OUT,
  output logic HOLD_REDUCE_OUT,
  output logic PUSH_SPEED_OUT,
  output logic signed [15:0] MOTION_TGT_OUT,
  output logic [7:0] CUR_LIMIT_OUT
);
  import phs_pkg::*;

  phs_cfg_t cfg;
  phs_state_t st, next_st;
  logic [23:0] cnt, next_cnt;
  logic [1:0] alm_code, next_code;
  logic next_done, next_load, next_alarm, next_servo, next_reduce, next_spd;
  logic signed [15:0] next_mtgt, pos_q;
  logic [2:0] start_sync;
  logic start_lvl, start_prev;
  logic wr_pend, rd_pend, wr_hit, rd_hit, alm_clr;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] rd_mux;

  // Bus decode.
  wire acc = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  wire addr_hit = (HADDR_IN[31:8] == 24'h000000) && (HADDR_IN[1:0] == 2'b00);
  wire wr_en = wr_pend && wr_hit;
  wire [31:0] status = {16'h0000, 6'h00, alm_code, 1'b0, ALARM_OUT, LOAD_OUT, POS_DONE_OUT, SERVO_ON_OUT, st};

  assign rd_mux = !rd_hit ? 32'h00000000 :
                  (rd_addr == ADDR_CTRL) ? {28'h0000000, cfg.tchk_off, cfg.ss_mode} :
                  (rd_addr == ADDR_TARGET) ? {16'h0000, cfg.target} :
                  (rd_addr == ADDR_BAND) ? {16'h0000, cfg.band} :
                  (rd_addr == ADDR_LIMITS) ? {16'h0000, cfg.thresh, cfg.push_lim} :
                  (rd_addr == ADDR_ZONE) ? {cfg.zone_hi, cfg.zone_lo} :
                  (rd_addr == ADDR_JUDGE) ? {16'h0000, cfg.judge} :
                  (rd_addr == ADDR_DLY1) ? {8'h00, cfg.dly1} :
                  (rd_addr == ADDR_DLY2) ? {8'h00, cfg.dly2} :
                  (rd_addr == ADDR_DLY3) ? {8'h00, cfg.dly3} :
                  (rd_addr == ADDR_STATUS) ? status : 32'h00000000;

  assign alm_clr = wr_en && (wr_addr == ADDR_ALM_CLR) && HWDATA_IN[0];

  // Writes complete with no wait state; reads insert one so they see a write just before them.
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wr_hit <= 1'b0;
      rd_hit <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
      HREADYOUT_OUT <= 1'b1;
      HRDATA_OUT <= 32'h00000000;
      HRESP_OUT <= 1'b0;
    end else begin
      wr_pend <= acc && HWRITE_IN;
      rd_pend <= acc && !HWRITE_IN;
      wr_hit <= addr_hit;
      rd_hit <= addr_hit;
      wr_addr <= HADDR_IN[7:0];
      rd_addr <= HADDR_IN[7:0];
      HREADYOUT_OUT <= !(acc && !HWRITE_IN);
      HRDATA_OUT <= rd_pend ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cfg <= '{ss_mode: SS_NONE, tchk_off: 1'b0, target: 16'h0000, band: RST_BAND, push_lim: 8'h00,
               thresh: 8'h00, zone_lo: 16'h0000, zone_hi: 16'h0000, judge: RST_JUDGE,
               dly1: RST_DLY, dly2: RST_DLY, dly3: RST_DLY};
    end else if (wr_en) begin
      if (wr_addr == ADDR_CTRL) begin
        cfg.ss_mode <= HWDATA_IN[CTRL_MODE_LSB +: 3];
        cfg.tchk_off <= HWDATA_IN[CTRL_TCHK_BIT];
      end
      if (wr_addr == ADDR_TARGET) cfg.target <= HWDATA_IN[15:0];
      if (wr_addr == ADDR_BAND) cfg.band <= HWDATA_IN[15:0];
      if (wr_addr == ADDR_LIMITS) begin
        cfg.push_lim <= HWDATA_IN[LIM_PUSH_LSB +: 8];
        cfg.thresh <= HWDATA_IN[LIM_THR_LSB +: 8];
      end
      if (wr_addr == ADDR_ZONE) begin
        cfg.zone_lo <= HWDATA_IN[ZONE_LO_LSB +: 16];
        cfg.zone_hi <= HWDATA_IN[ZONE_HI_LSB +: 16];
      end
      if (wr_addr == ADDR_JUDGE) cfg.judge <= HWDATA_IN[15:0];
      if (wr_addr == ADDR_DLY1) cfg.dly1 <= HWDATA_IN[23:0];
      if (wr_addr == ADDR_DLY2) cfg.dly2 <= HWDATA_IN[23:0];
      if (wr_addr == ADDR_DLY3) cfg.dly3 <= HWDATA_IN[23:0];
    end
  end

  // Start pin: three flops, a level change counts once the last two agree.
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      start_sync <= 3'b000;
      start_lvl <= 1'b0;
      start_prev <= 1'b0;
    end else begin
      start_sync <= {start_sync[1:0], START_IN};
      if (start_sync[1] == start_sync[2]) start_lvl <= start_sync[2];
      start_prev <= start_lvl;
    end
  end

  // Position and current conditions.
  wire start_evt = start_lvl && !start_prev;
  wire push_mode = cfg.push_lim != 8'h00;
  wire dir_pos = !cfg.band[15];
  wire signed [15:0] end_pos = 16'(cfg.target + cfg.band);
  wire signed [16:0] diff = 17'(cfg.target) - 17'(ACT_POS_IN);
  wire [16:0] adiff = diff[16] ? 17'(-diff) : 17'(diff);
  wire [16:0] aband = cfg.band[15] ? 17'(-17'(cfg.band)) : 17'(cfg.band);
  wire in_band = adiff <= aband;
  wire at_tgt = ACT_POS_IN == cfg.target;
  wire past_end = dir_pos ? (ACT_POS_IN >= end_pos) : (ACT_POS_IN <= end_pos);
  wire back_at_tgt = dir_pos ? (ACT_POS_IN <= cfg.target) : (ACT_POS_IN >= cfg.target);
  wire moving_back = dir_pos ? (ACT_POS_IN < pos_q) : (ACT_POS_IN > pos_q);
  wire at_lim = MOTOR_CUR_IN >= cfg.push_lim;
  wire trq_hit = CMD_TORQUE_IN >= cfg.thresh;
  wire in_zone = (ACT_POS_IN >= cfg.zone_lo) && (ACT_POS_IN <= cfg.zone_hi);
  wire judged = (cnt + 24'h000001) >= {8'h00, cfg.judge};
  wire auto_off = (cfg.ss_mode == SS_OFF1) || (cfg.ss_mode == SS_OFF2) || (cfg.ss_mode == SS_OFF3);
  wire [23:0] ss_dly = (cfg.ss_mode == SS_OFF1) ? cfg.dly1 : (cfg.ss_mode == SS_OFF2) ? cfg.dly2 : cfg.dly3;
  wire accept = start_evt && ((st == ST_IDLE) || (st == ST_DONE) || (st == ST_HOLD) || (st == ST_MISS));

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_done = POS_DONE_OUT;
    next_load = LOAD_OUT;
    next_alarm = ALARM_OUT;
    next_code = alm_code;
    next_servo = SERVO_ON_OUT;
    next_reduce = HOLD_REDUCE_OUT;
    next_spd = PUSH_SPEED_OUT;
    next_mtgt = MOTION_TGT_OUT;
    unique case (st)
      ST_IDLE: begin
      end
      ST_WAKE: begin
        next_cnt = cnt + 24'h000001;
        if (next_cnt >= WAKE_CYC) begin
          next_st = ST_MOVE;
          next_cnt = 24'h000000;
        end
      end
      ST_MOVE: begin
        if (push_mode) begin
          if (at_tgt) begin
            next_st = ST_PUSH;
            next_mtgt = end_pos;
            next_spd = 1'b1;
            next_cnt = 24'h000000;
          end else if (at_lim) begin
            next_st = ST_ALARM;
            next_alarm = 1'b1;
            next_code = ALM_EARLY;
          end
        end else if (in_band) begin
          next_st = ST_DONE;
          next_done = 1'b1;
          next_cnt = 24'h000000;
        end
      end
      ST_PUSH: begin
        if (cfg.tchk_off) next_load = trq_hit;
        else if (trq_hit && in_zone) next_load = 1'b1;
        if (at_lim) begin
          next_cnt = cnt + 24'h000001;
          if (judged) begin
            next_st = ST_HOLD;
            next_done = 1'b1;
          end
        end else begin
          next_cnt = 24'h000000;
          if (past_end) next_st = ST_MISS;
        end
      end
      ST_HOLD: begin
        // The motion target stays at the band end, so a yielding load is followed up to the band end.
        next_done = at_lim || moving_back;
        if (cfg.tchk_off) next_load = trq_hit;
        if (back_at_tgt) begin
          next_st = ST_ALARM;
          next_alarm = 1'b1;
          next_code = ALM_PUSHBACK;
        end
      end
      ST_DONE, ST_MISS: begin
        next_reduce = SERVO_ON_OUT && (cfg.ss_mode == SS_FULL);
        if (auto_off && SERVO_ON_OUT) begin
          next_cnt = cnt + 24'h000001;
          if (next_cnt >= ss_dly) next_servo = 1'b0;
        end
      end
      ST_ALARM: begin
        next_servo = 1'b0;
        next_done = 1'b0;
        next_load = 1'b0;
        next_spd = 1'b0;
        next_reduce = 1'b0;
        if (alm_clr) begin
          next_st = ST_IDLE;
          next_alarm = 1'b0;
          next_code = ALM_NONE;
        end
      end
    endcase
    if (accept) begin
      next_done = 1'b0;
      next_load = 1'b0;
      next_reduce = 1'b0;
      next_spd = 1'b0;
      next_cnt = 24'h000000;
      next_mtgt = cfg.target;
      next_servo = 1'b1;
      next_st = SERVO_ON_OUT ? ST_MOVE : ST_WAKE;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      st <= ST_IDLE;
      cnt <= 24'h000000;
      alm_code <= ALM_NONE;
      pos_q <= 16'h0000;
      POS_DONE_OUT <= 1'b0;
      LOAD_OUT <= 1'b0;
      ALARM_OUT <= 1'b0;
      SERVO_ON_OUT <= 1'b0;
      HOLD_REDUCE_OUT <= 1'b0;
      PUSH_SPEED_OUT <= 1'b0;
      MOTION_TGT_OUT <= 16'h0000;
      CUR_LIMIT_OUT <= 8'h00;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      alm_code <= next_code;
      pos_q <= ACT_POS_IN;
      POS_DONE_OUT <= next_done;
      LOAD_OUT <= next_load;
      ALARM_OUT <= next_alarm;
      SERVO_ON_OUT <= next_servo;
      HOLD_REDUCE_OUT <= next_reduce;
      PUSH_SPEED_OUT <= next_spd;
      MOTION_TGT_OUT <= next_mtgt;
      CUR_LIMIT_OUT <= cfg.push_lim;
    end
  end

  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);

  sequence cmd_taken_s;
    accept;
  endsequence
  sequence outputs_low_s;
    !POS_DONE_OUT && !LOAD_OUT;
  endsequence

  new_cmd_clear_a: assert property (cmd_taken_s |=> outputs_low_s)
    else $error("Complete or load output still high after a new command.");
  servo_wake_a: assert property (accept && !SERVO_ON_OUT |=> SERVO_ON_OUT && st == ST_WAKE ##5 st == ST_MOVE)
    else $error("Servo wake did not lead to motion in five cycles.");
  full_servo_a: assert property (st == ST_DONE && cfg.ss_mode == SS_FULL && SERVO_ON_OUT && !accept
                                 |=> SERVO_ON_OUT && HOLD_REDUCE_OUT)
    else $error("Full servo mode did not hold servo with reduced current.");
  auto_off_a: assert property ($fell(SERVO_ON_OUT) && !ALARM_OUT |-> $past(auto_off) && $past(cnt) + 24'h000001 >= $past(ss_dly))
    else $error("Servo dropped before the standstill delay.");
  plain_done_a: assert property (st == ST_MOVE && !push_mode && in_band && !accept |=> POS_DONE_OUT && st == ST_DONE)
    else $error("Plain positioning did not complete inside the band.");
  early_contact_a: assert property (st == ST_MOVE && push_mode && !at_tgt && at_lim |=> ALARM_OUT && alm_code == ALM_EARLY)
    else $error("Contact before target raised no alarm.");
  // Only the rise that ends the push phase is judged here; rises inside HOLD follow the current level or a push-back instead.
  push_judge_a: assert property ($rose(POS_DONE_OUT) && $past(st) == ST_PUSH |-> st == ST_HOLD && $past(at_lim) && $past(judged))
    else $error("Push completion without the current limit held.");
  miss_low_a: assert property (st == ST_MISS |-> !POS_DONE_OUT)
    else $error("Complete asserted after a missed load.");
  hold_track_a: assert property (st == ST_HOLD && !at_lim && !moving_back && !back_at_tgt && !accept |=> !POS_DONE_OUT)
    else $error("Complete stayed high with current under the limit.");
  pushback_alm_a: assert property (st == ST_HOLD && back_at_tgt && !accept |=> ALARM_OUT && alm_code == ALM_PUSHBACK)
    else $error("Push-back to target raised no alarm.");
  // A pushed-back actuator keeps complete asserted while it yields, whatever the current does.
  pushback_keep_a: assert property (st == ST_HOLD && moving_back && !back_at_tgt && !accept |=> POS_DONE_OUT)
    else $error("Complete dropped while the actuator was pushed back.");
  load_level_a: assert property (st == ST_PUSH && cfg.tchk_off && !accept |=> LOAD_OUT == $past(trq_hit))
    else $error("Load output does not follow torque level.");

endmodule : phs_ctrl

// ===== tb/phs_plc.sv
// PLC and actuator mechanics model facing the push/hold controller.
module phs_plc (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rstn_in,
  // From the controller.
  input wire logic servo_in,
  input wire logic done_in,
  input wire logic alarm_in,
  input wire logic signed [15:0] tgt_in,
  // Scenario controls.
  input wire logic load_en_in,
  input wire logic signed [15:0] load_in,
  input wire logic drop_in,
  // To the controller.
  output logic start_out,
  output logic signed [15:0] pos_out,
  output logic [7:0] cur_out,
  output logic [7:0] trq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic touch;
  assign touch = load_en_in && pos_out >= load_in;
  assign cur_out = touch ? 8'h64 : 8'h05;
  assign trq_out = drop_in ? 8'h00 : cur_out;
  initial start_out = 1'b0;
  // A load ahead of the actuator shoves it back; one step a cycle keeps the push slow.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pos_out <= 16'sh0000;
    end else if (load_en_in && pos_out > load_in) begin
      pos_out <= load_in;
    end else if (servo_in && !touch && pos_out < tgt_in) begin
      pos_out <= pos_out + 16'sh0001;
    end
  end
  task automatic press();
    @(posedge clk_in);
    start_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    start_out <= 1'b0;
  endtask : press
  // The PLC gives up after lim cycles, so a missed load shows as no completion.
  task automatic wait_done(input int lim, output logic got);
    for (int i = 0; i < lim; i++) begin
      @(posedge clk_in);
      if (done_in === 1'b1 || alarm_in === 1'b1) begin
        break;
      end
    end
    got = done_in;
  endtask : wait_done
endmodule : phs_plc

// ===== tb/phs_ctrl_test.sv
// Self-checking bench for the push/hold standstill controller.
module phs_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import phs_pkg::*;
  logic clk, rstn, hsel, hwr, len, drop, start, rd_ph, got, hrdy, hresp;
  logic done, load, alarm, servo, hred, pspd;
  logic [1:0] htr;
  logic [31:0] haddr, hwd, hrd;
  logic signed [15:0] pos, mtgt, lpos, tgt;
  logic [7:0] cur, trq, clim;
  logic [63:0] notes[$];
  int error_cnt, total_checks, n;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  phs_ctrl dut (
    .SYS_CLK_IN(clk), .RSTN_IN(rstn), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htr),
    .HWRITE_IN(hwr), .HSIZE_IN(3'h2), .HWDATA_IN(hwd), .HREADY_IN(hrdy), .HRDATA_OUT(hrd),
    .HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp), .START_IN(start), .ACT_POS_IN(pos),
    .MOTOR_CUR_IN(cur), .CMD_TORQUE_IN(trq), .POS_DONE_OUT(done), .LOAD_OUT(load),
    .ALARM_OUT(alarm), .SERVO_ON_OUT(servo), .HOLD_REDUCE_OUT(hred), .PUSH_SPEED_OUT(pspd),
    .MOTION_TGT_OUT(mtgt), .CUR_LIMIT_OUT(clim)
  );
  phs_plc m_plc (
    .clk_in(clk), .rstn_in(rstn), .servo_in(servo), .done_in(done), .alarm_in(alarm),
    .tgt_in(mtgt), .load_en_in(len), .load_in(lpos), .drop_in(drop), .start_out(start),
    .pos_out(pos), .cur_out(cur), .trq_out(trq)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  // A read notes its expected word and mask; the monitor below settles it.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    hsel <= 1'b1;
    htr <= 2'b10;
    haddr <= {24'h000000, a};
    hwr <= w;
    if (!w) begin
      notes.push_back({m, d & m});
    end
    do @(posedge clk); while (hrdy !== 1'b1);
    htr <= 2'b00;
    hwd <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
  endtask : ahb
  always @(posedge clk) begin
    if (rd_ph === 1'b1 && hrdy === 1'b1) begin
      chk(hrd & notes[0][63:32], notes[0][31:0]);
      void'(notes.pop_front());
    end
    if (hrdy === 1'b1) begin
      rd_ph <= hsel && htr[1] && !hwr;
    end
  end
  function automatic logic sig(input int w);
    case (w)
      0: return done;
      1: return alarm;
      2: return servo;
      default: return cur >= 8'h32;
    endcase
  endfunction : sig
  task automatic till(input int w, input logic v, input int cap);
    n = 0;
    while (sig(w) !== v && n < cap) begin
      @(posedge clk);
      n++;
    end
  endtask : till
  task automatic rst();
    rstn <= 1'b0;
    len <= 1'b0;
    drop <= 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
  endtask : rst
  task automatic run(input logic [3:0] ctl, input logic [7:0] lim, input int zl, input int zh, input int lo,
                     input logic le);
    rst();
    tgt = 16'(30 + $urandom % 40);
    ahb(1'b1, ADDR_CTRL, {28'h0, ctl}, 32'h0);
    ahb(1'b1, ADDR_TARGET, {16'h0, tgt}, 32'h0);
    ahb(1'b1, ADDR_BAND, 32'h8, 32'h0);
    ahb(1'b1, ADDR_LIMITS, {16'h0, 8'h28, lim}, 32'h0);
    ahb(1'b1, ADDR_ZONE, {16'(tgt + zh), 16'(tgt + zl)}, 32'h0);
    for (int i = 0; i < 3; i++) begin
      ahb(1'b1, ADDR_DLY1 + 8'(4 * i), 32'(10 + 4 * i), 32'h0);
    end
    lpos <= 16'(tgt + lo);
    len <= le;
    m_plc.press();
  endtask : run
  initial begin
    {rstn, hsel, hwr, len, drop, rd_ph} = 6'h00;
    htr = 2'b00;
    haddr = 32'h0;
    hwd = 32'h0;
    lpos = 16'sh0000;
    error_cnt = 0;
    total_checks = 0;
    void'($urandom(32'heb35));
    rst();
    ahb(1'b0, ADDR_JUDGE, {16'h0, RST_JUDGE}, 32'hffffffff);
    ahb(1'b0, ADDR_DLY2, {8'h0, RST_DLY}, 32'hffffffff);
    ahb(1'b0, ADDR_BAND, {16'h0, RST_BAND}, 32'hffffffff);
    ahb(1'b1, ADDR_STATUS, 32'hffffffff, 32'h0);
    ahb(1'b0, ADDR_STATUS, 32'h0, 32'hffffffff);
    ahb(1'b0, 8'h2c, 32'h0, 32'hffffffff);
    chk(hresp, 1'b0);
    // Every standstill code, plain positioning.
    for (int m = 0; m < 5; m++) begin
      run(4'(m), 8'h00, 0, 0, 0, 1'b0);
      m_plc.wait_done(400, got);
      chk({got, pspd}, 2'b10);
      chk(32'(tgt - pos >= 4 && tgt - pos <= 8), 32'h1);
      till(2, 1'b0, 40);
      if (m >= 1 && m <= 3) begin
        chk(32'(n >= 4 + 4 * m && n <= 9 + 4 * m), 32'h1);
      end else begin
        chk({n[7:0], hred}, {8'd40, 1'(m == 4)});
      end
      if (m == 1) begin
        tgt = 16'(tgt + 20);
        ahb(1'b1, ADDR_TARGET, {16'h0, tgt}, 32'h0);
        m_plc.press();
        chk({servo, done}, 2'b10);
        m_plc.wait_done(400, got);
        chk(got, 1'b1);
      end
    end
    // Push into a load, then the load yields and pushes back.
    run(4'h0, 8'h32, 0, 8, 3, 1'b1);
    till(3, 1'b1, 300);
    till(0, 1'b1, 60);
    chk(32'(n >= RST_JUDGE - 1 && n <= RST_JUDGE + 2), 32'h1);
    chk({pspd, mtgt}, {1'b1, 16'(tgt + 8)});
    chk(clim, 8'h32);
    drop <= 1'b1;
    repeat (3) @(posedge clk);
    chk(load, 1'b1);
    lpos <= 16'(tgt + 5);
    till(0, 1'b0, 20);
    chk(done, 1'b0);
    till(0, 1'b1, 20);
    chk({done, pos}, {1'b1, 16'(tgt + 5)});
    lpos <= 16'(tgt + 2);
    repeat (3) @(posedge clk);
    chk({done, alarm}, 2'b10);
    lpos <= tgt;
    till(1, 1'b1, 20);
    ahb(1'b0, ADDR_STATUS, {22'h0, ALM_PUSHBACK, 1'b0, 1'b1, 6'h0}, 32'h340);
    // No load within the band.
    run(4'h0, 8'h32, 0, 8, 0, 1'b0);
    m_plc.wait_done(200, got);
    chk(got, 1'b0);
    ahb(1'b0, ADDR_STATUS, {29'h0, ST_MISS}, 32'h7);
    // Load met before the target, then the alarm is cleared.
    run(4'h0, 8'h32, 0, 8, -5, 1'b1);
    till(1, 1'b1, 300);
    chk(done, 1'b0);
    ahb(1'b0, ADDR_STATUS, {22'h0, ALM_EARLY, 1'b0, 1'b1, 6'h0}, 32'h340);
    ahb(1'b1, ADDR_ALM_CLR, 32'h1, 32'h0);
    ahb(1'b0, ADDR_STATUS, {29'h0, ST_IDLE}, 32'h47);
    // Torque check without a band follows the torque level.
    run(4'h8, 8'h32, 0, 8, 3, 1'b1);
    m_plc.wait_done(300, got);
    repeat (2) @(posedge clk);
    chk(load, 1'b1);
    drop <= 1'b1;
    repeat (3) @(posedge clk);
    chk(load, 1'b0);
    drop <= 1'b0;
    repeat (3) @(posedge clk);
    chk(load, 1'b1);
    m_plc.press();
    chk({load, done}, 2'b00);
    // Torque check with the contact outside the band.
    run(4'h0, 8'h32, 6, 8, 3, 1'b1);
    m_plc.wait_done(300, got);
    chk({got, load}, 2'b10);
    test_done();
  end
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule : phs_ctrl_test
